// ---- include/afa_cfg.svh ----
// Constants of the automatic fault acknowledgement controller.
// Assumes a 20 MHz control clock; included by bare name.
`ifndef AFA_CFG_SVH
`define AFA_CFG_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define AFA_CLK_HZ        20000000
`define AFA_ACK_DELAY_S   3
`define AFA_ACK_DELAY_CYC (`AFA_ACK_DELAY_S * `AFA_CLK_HZ)

// ------------------------------------------------------------
// Setting values and reset value
// ------------------------------------------------------------
`define AFA_SET_NONE      3'h0
`define AFA_SET_CNT_MAX   3'h5
`define AFA_SET_ALWAYS    3'h6
`define AFA_SET_KEY_ONLY  3'h7
`define AFA_SET_RESET     3'h0

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define AFA_ADDR_CTRL     2'h0
`define AFA_ADDR_STAT     2'h1
`define AFA_ADDR_MASK     2'h2
`define AFA_ADDR_LEFT     2'h3

`endif

// ---- include/afa_pkg.sv ----
// Types of the automatic fault acknowledgement controller.
// Assumes nothing of its surroundings.
package afa_pkg;

    // ------------------------------------------------------------
    // Fault state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AFA_IDLE,
        AFA_WAIT_CAUSE,
        AFA_WAIT_DELAY
    } afa_state_t;

    typedef logic [2:0] afa_setting_t;

endpackage : afa_pkg

// ---- src/afa_core.sv ----
// Fault latch and acknowledgement decision for a motor drive unit.
// Assumes fault and cause from same-clock logic; key, enable and the
// power-on strobe come from pins and are synchronised here.
`include "afa_cfg.svh"

module afa_core #(
    parameter int unsigned ACK_DELAY_CYC = `AFA_ACK_DELAY_CYC
) (
    // Clock, reset, enable
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              clk_en_in,
    // Configuration
    input  wire afa_pkg::afa_setting_t auto_fault_ack_setting_in,
    input  wire logic              setting_load_in,
    input  wire logic              terminal_ctrl_in,
    // Fault source
    input  wire logic              fault_trip_in,
    input  wire logic              fault_cause_in,
    // Operator and mains
    input  wire logic              enter_key_in,
    input  wire logic              drive_enable_in,
    input  wire logic              power_on_in,
    // Register port
    input  wire logic [1:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [7:0]        reg_rdata_out,
    // Status
    output logic                   fault_latched_out,
    output logic                   drive_off_out,
    output logic [2:0]             auto_ack_left_out,
    output logic                   irq_out
);
    import afa_pkg::*;

    // Elaboration check: a zero delay would wrap the limit ACK_DELAY_CYC - 1 to all ones
    if (ACK_DELAY_CYC < 1) begin : g_bad_delay
        $error("ACK_DELAY_CYC must be at least one");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Three stages; a change counts only once stages two and three agree
    logic [2:0] key_sync_reg;
    logic [2:0] en_sync_reg;
    logic [2:0] pwr_sync_reg;
    logic       key_reg;
    logic       en_reg;
    logic       pwr_reg;
    logic       key_prev_reg;
    logic       en_prev_reg;
    logic       pwr_prev_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            key_sync_reg <= 3'h0;
            en_sync_reg  <= 3'h0;
            pwr_sync_reg <= 3'h0;
        end else if (clk_en_in) begin
            key_sync_reg <= {key_sync_reg[1:0], enter_key_in};
            en_sync_reg  <= {en_sync_reg[1:0], drive_enable_in};
            pwr_sync_reg <= {pwr_sync_reg[1:0], power_on_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            key_reg      <= 1'b0;
            en_reg       <= 1'b0;
            pwr_reg      <= 1'b0;
            key_prev_reg <= 1'b0;
            en_prev_reg  <= 1'b0;
            pwr_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (key_sync_reg[1] == key_sync_reg[2]) begin
                key_reg <= key_sync_reg[2];
            end
            if (en_sync_reg[1] == en_sync_reg[2]) begin
                en_reg <= en_sync_reg[2];
            end
            if (pwr_sync_reg[1] == pwr_sync_reg[2]) begin
                pwr_reg <= pwr_sync_reg[2];
            end
            key_prev_reg <= key_reg;
            en_prev_reg  <= en_reg;
            pwr_prev_reg <= pwr_reg;
        end
    end

    logic key_press;
    logic en_drop;
    logic power_up;
    assign key_press = key_reg & ~key_prev_reg;
    assign en_drop   = ~en_reg & en_prev_reg;
    assign power_up  = pwr_reg & ~pwr_prev_reg;

    // ------------------------------------------------------------
    // Setting
    // ------------------------------------------------------------
    afa_setting_t setting_reg;

    // Resets to no automatic acknowledgement
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            setting_reg <= `AFA_SET_RESET;
        end else if (clk_en_in && setting_load_in) begin
            setting_reg <= auto_fault_ack_setting_in;
        end
    end

    logic mode_count;
    logic mode_always;
    logic mode_key_only;
    assign mode_count    = (setting_reg != `AFA_SET_NONE) &&
                           (setting_reg <= `AFA_SET_CNT_MAX);
    assign mode_always   = (setting_reg == `AFA_SET_ALWAYS);
    assign mode_key_only = (setting_reg == `AFA_SET_KEY_ONLY);

    // ------------------------------------------------------------
    // Acknowledgement sources
    // ------------------------------------------------------------
    logic       manual_ack;
    logic       auto_ok;
    logic       auto_ack;
    logic [2:0] left_reg;
    logic       delay_done;
    afa_state_t state_reg;

    // Enable withdrawal acknowledges only under terminal control
    assign manual_ack = key_press | power_up |
                        (en_drop & terminal_ctrl_in &
                         ~mode_key_only);
    // Setting zero and seven never permit an automatic clear
    assign auto_ok    = mode_always |
                        (mode_count && left_reg != 3'h0);
    assign auto_ack   = (state_reg == AFA_WAIT_DELAY) && delay_done &&
                        auto_ok;

    // ------------------------------------------------------------
    // Fault state machine and delay counter
    // ------------------------------------------------------------
    logic [31:0] delay_reg;
    assign delay_done = (delay_reg >= ACK_DELAY_CYC - 1);

    // Latched until a permitted source clears it
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= AFA_IDLE;
        end else if (clk_en_in) begin
            unique case (state_reg)
                AFA_IDLE: begin
                    if (fault_trip_in) begin
                        state_reg <= AFA_WAIT_CAUSE;
                    end
                end
                AFA_WAIT_CAUSE: begin
                    if (manual_ack) begin
                        state_reg <= AFA_IDLE;
                    end else if (!fault_cause_in) begin
                        state_reg <= AFA_WAIT_DELAY;
                    end
                end
                AFA_WAIT_DELAY: begin
                    if (manual_ack || auto_ack) begin
                        state_reg <= AFA_IDLE;
                    end else if (fault_cause_in) begin
                        state_reg <= AFA_WAIT_CAUSE;
                    end
                end
            endcase
        end
    end

    // Counts while acknowledgeable; saturates so a later setting change
    // to an automatic mode clears at once
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            delay_reg <= 32'h0;
        end else if (clk_en_in) begin
            if (state_reg != AFA_WAIT_DELAY || fault_cause_in) begin
                delay_reg <= 32'h0;
            end else if (!delay_done) begin
                delay_reg <= delay_reg + 32'h1;
            end
        end
    end

    // Remaining count, reloaded on each power-up
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            left_reg <= 3'h0;
        end else if (clk_en_in) begin
            if (power_up || setting_load_in) begin
                left_reg <= setting_load_in ? auto_fault_ack_setting_in
                                            : setting_reg;
            end else if (auto_ack && mode_count && !manual_ack) begin
                left_reg <= left_reg - 3'h1;
            end
        end
    end

    assign fault_latched_out = (state_reg != AFA_IDLE);
    assign drive_off_out     = fault_latched_out;
    assign auto_ack_left_out = mode_count ? left_reg : 3'h0;

    // ------------------------------------------------------------
    // Interrupt status and register port
    // ------------------------------------------------------------
    // Bit0 trip, bit1 auto clear, bit2 manual clear
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] ev;
    logic       trip_ev;
    assign trip_ev = (state_reg == AFA_IDLE) && fault_trip_in;
    assign ev = {manual_ack && fault_latched_out,
                 auto_ack && !manual_ack, trip_ev};

    // Read clears; a same-cycle event still wins
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_stat_reg <= 3'h0;
        end else if (clk_en_in) begin
            if (reg_rd_in && reg_addr_in == `AFA_ADDR_STAT) begin
                irq_stat_reg <= ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_mask_reg <= 3'h0;
        end else if (clk_en_in && reg_wr_in &&
                     reg_addr_in == `AFA_ADDR_MASK) begin
            irq_mask_reg <= reg_wdata_in[2:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h0;
        end else if (clk_en_in) begin
            reg_rdata_out <= 8'h0;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    `AFA_ADDR_CTRL: reg_rdata_out <= {2'h0, state_reg, 1'b0,
                                                     setting_reg};
                    `AFA_ADDR_STAT: reg_rdata_out <= {5'h0, irq_stat_reg};
                    `AFA_ADDR_MASK: reg_rdata_out <= {5'h0, irq_mask_reg};
                    `AFA_ADDR_LEFT: reg_rdata_out <= {5'h0, left_reg};
                endcase
            end
        end
    end

    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_acked;
        fault_latched_out ##1 !fault_latched_out;
    endsequence

    chk_zero_no_auto: assert property (
        clk_en_in && setting_reg == `AFA_SET_NONE && fault_latched_out &&
        !manual_ack |=> fault_latched_out)
        else $error("auto clear in setting zero");
    chk_key_only: assert property (
        clk_en_in && mode_key_only && fault_latched_out && !manual_ack
        |=> fault_latched_out)
        else $error("auto clear in key-only setting");
    chk_enable_ignored: assert property (
        clk_en_in && mode_key_only && en_drop && !key_press &&
        !power_up && fault_latched_out |=> fault_latched_out)
        else $error("enable removal acked in key-only setting");
    chk_enable_acks: assert property (
        clk_en_in && !mode_key_only && en_drop && terminal_ctrl_in &&
        fault_latched_out |=> !fault_latched_out)
        else $error("enable removal not acked");
    chk_count_down: assert property (
        clk_en_in && auto_ack && mode_count && !manual_ack &&
        !power_up && !setting_load_in |=> left_reg == $past(left_reg) - 1)
        else $error("count not decremented");
    chk_count_limit: assert property (
        clk_en_in && mode_count && left_reg == 3'h0 && fault_latched_out &&
        !manual_ack |=> fault_latched_out)
        else $error("auto clear beyond permitted count");
    chk_reload: assert property (
        clk_en_in && power_up && !setting_load_in
        |=> left_reg == $past(setting_reg))
        else $error("count not reloaded on power-up");
    chk_delay: assert property (
        auto_ack |-> delay_reg == ACK_DELAY_CYC - 1)
        else $error("auto clear before delay elapsed");
    chk_latched_drive: assert property (
        fault_latched_out |-> drive_off_out)
        else $error("drive enabled while fault latched");
    chk_clear_source: assert property (
        s_acked |-> $past(manual_ack) || $past(auto_ack))
        else $error("fault cleared without a source");

endmodule : afa_core

// ---- verif/afa_operator_model.sv ----
// Operator side of the drive: ENTER key, enable input, mains supply.
// Assumes commands from the bench clock domain, one at a time.
module afa_operator_model (
    // Clock and command
    input  wire logic       clk_in,
    input  wire logic [1:0] cmd_in,
    input  wire logic       go_in,
    // Pins toward the drive
    output logic            enter_key_out,
    output logic            drive_enable_out,
    output logic            power_on_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pins: key up, enable given, mains still off until the first mains-cycle command
    initial begin
        enter_key_out = 1'b0;
        drive_enable_out = 1'b1;
        power_on_out = 1'b0;
    end

    // Each action lasts 12 cycles, long enough for the pin synchroniser
    always @(posedge clk_in) begin
        if (go_in) begin
            enter_key_out <= (cmd_in == 2'h1);
            drive_enable_out <= (cmd_in != 2'h2);
            power_on_out <= power_on_out && (cmd_in != 2'h3);
            repeat (12) @(posedge clk_in);
            enter_key_out <= 1'b0;
            drive_enable_out <= 1'b1;
            power_on_out <= power_on_out || (cmd_in == 2'h3);
        end
    end
endmodule : afa_operator_model

// ---- verif/afa_tb_top.sv ----
// Self-checking bench of the fault acknowledgement controller.
// Assumes a short acknowledge delay so the run stays brief.
module afa_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import afa_pkg::*;
    localparam int ACK = 20;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_in = 1'b0, sys_rst_in = 1'b1, ld = 1'b0, term = 1'b0;
    logic trip = 1'b0, cause = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic ce = 1'b1;
    logic [1:0] cmd = 2'h0, addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    afa_setting_t setting = 3'h0;
    logic key, en, pwr, lat, off, irq;
    logic [2:0] left;
    int n_errors = 0, n_compared = 0, k;

    // Clock at 20 MHz
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    afa_operator_model i_op (.clk_in(clk_in), .cmd_in(cmd), .go_in(go),
        .enter_key_out(key), .drive_enable_out(en), .power_on_out(pwr));

    afa_core #(.ACK_DELAY_CYC(ACK)) i_dut (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .clk_en_in(ce),
        .auto_fault_ack_setting_in(setting), .setting_load_in(ld),
        .terminal_ctrl_in(term), .fault_trip_in(trip),
        .fault_cause_in(cause), .enter_key_in(key),
        .drive_enable_in(en), .power_on_in(pwr), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .fault_latched_out(lat),
        .drive_off_out(off), .auto_ack_left_out(left), .irq_out(irq));

    task automatic chk(input string nm, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // Remaining automatic clears after some have been used
    function automatic logic [7:0] exp_left(input int s, input int used);
        return 8'(s - used);
    endfunction : exp_left

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    task automatic chk_lat(input logic e);
        chk("fault_latched", {7'h00, lat}, {7'h00, e});
    endtask : chk_lat

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // Operator action: 1 key, 2 enable removed, 3 mains cycled
    task automatic act(input logic [1:0] c);
        @(posedge clk_in);
        cmd <= c;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        cyc(30);
    endtask : act

    task automatic set_mode(input afa_setting_t v);
        @(posedge clk_in);
        setting <= v;
        ld <= 1'b1;
        @(posedge clk_in);
        ld <= 1'b0;
        cyc(1);
    endtask : set_mode

    task automatic trip_fault();
        @(posedge clk_in);
        cause <= 1'b1;
        trip <= 1'b1;
        @(posedge clk_in);
        trip <= 1'b0;
        cyc(2);
        chk_lat(1'b1);
        chk("drive_off", {7'h00, off}, 8'h01);
    endtask : trip_fault

    // Cause removed: nothing before the delay, then cleared or not
    task automatic drop_cause(input logic clears);
        @(posedge clk_in);
        cause <= 1'b0;
        cyc(ACK - 3);
        chk_lat(1'b1);
        cyc(8);
        chk_lat(!clears);
    endtask : drop_cause

    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // Watchdog well beyond the expected run of about a thousand cycles
    initial begin
        #(20000 * 50);
        n_errors++;
        results();
    end

    initial begin
        void'($urandom(32'h662a));
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        cyc(1);
        rd_reg(2'h0, d);
        chk("setting", d, 8'h00);
        act(2'h3);
        $display("test reset done");
        // Interrupt masked, unmasked, then cleared by the status read
        wr_reg(2'h2, 8'h00);
        rd_reg(2'h1, d);
        trip_fault();
        chk("irq", {7'h00, irq}, 8'h00);
        wr_reg(2'h2, 8'h01);
        cyc(1);
        chk("irq", {7'h00, irq}, 8'h01);
        rd_reg(2'h1, d);
        chk("status", d, 8'h01);
        chk("irq", {7'h00, irq}, 8'h00);
        wr_reg(2'h3, 8'($urandom)); // Read-only place, write ignored
        rd_reg(2'h2, d);
        chk("mask", d, 8'h01);
        drop_cause(1'b0);
        act(2'h1);
        chk_lat(1'b0);
        $display("test setting zero done");
        // Limited count, then mains cycle reloads it
        k = $urandom_range(5, 1);
        set_mode(3'(k));
        for (int i = 0; i <= k; i++) begin
            chk("left", {5'h00, left}, exp_left(k, i));
            trip_fault();
            drop_cause(i < k);
        end
        act(2'h1);
        chk_lat(1'b0);
        act(2'h3);
        chk("left", {5'h00, left}, exp_left(k, 0));
        rd_reg(2'h3, d);
        chk("left_reg", d, exp_left(k, 0));
        $display("test counted done");
        set_mode(3'h6);
        repeat (7) begin
            trip_fault();
            cyc(10 + $urandom_range(40, 0));
            chk_lat(1'b1);
            drop_cause(1'b1);
        end
        rd_reg(2'h1, d);
        chk("status", d, 8'h07);
        $display("test always done");
        // Enable removal under terminal control, refused in setting 7
        term <= 1'b1;
        set_mode(3'h0);
        trip_fault();
        act(2'h2);
        chk_lat(1'b0);
        set_mode(3'h7);
        trip_fault();
        drop_cause(1'b0);
        act(2'h2);
        chk_lat(1'b1);
        rd_reg(2'h0, d);
        chk("ctrl", d, 8'h27);
        // Clock enable low: the key press is never seen
        ce <= 1'b0;
        act(2'h1);
        chk_lat(1'b1);
        ce <= 1'b1;
        act(2'h1);
        chk_lat(1'b0);
        trip_fault();
        act(2'h3);
        chk_lat(1'b0);
        rd_reg(2'h1, d);
        chk("status", d, 8'h05);
        $display("test key only done");
        results();
    end
endmodule : afa_tb_top
